// ===== hw/smwp_pkg.sv
`default_nettype none
package smwp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Opcodes.
  localparam logic [7:0] OP_LATCH_SET    = 8'h06;
  localparam logic [7:0] OP_LATCH_CLEAR  = 8'h04;
  localparam logic [7:0] OP_STATUS_READ  = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_MEM_WRITE    = 8'h02;

  ////////////////////////////////////////////////////////////////////////////
  // Status byte layout.
  localparam int BIT_BUSY   = 0;
  localparam int BIT_LATCH  = 1;
  localparam int BIT_SEL_LO = 2;
  localparam int BIT_SEL_HI = 3;
  localparam int BIT_ZERO_LO = 4;
  localparam int BIT_ZERO_HI = 5;
  localparam int BIT_ONE    = 6;
  localparam int BIT_PGE    = 7;

  localparam logic       FACTORY_PGE = 1'b0;
  localparam logic [1:0] FACTORY_SEL = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Block protection ranges.
  localparam int         ADDR_W       = 18;
  localparam logic [1:0] SEL_NONE     = 2'h0;
  localparam logic [1:0] SEL_QUARTER  = 2'h1;
  localparam logic [1:0] SEL_HALF     = 2'h2;
  localparam logic [1:0] SEL_ALL      = 2'h3;
  localparam logic [17:0] BASE_QUARTER = 18'h30000;
  localparam logic [17:0] BASE_HALF    = 18'h20000;
  localparam logic [17:0] BASE_ALL     = 18'h00000;
  localparam logic [17:0] ADDR_LAST    = 18'h3ffff;
  localparam logic [17:0] ADDR_STEP    = 18'h00001;

  ////////////////////////////////////////////////////////////////////////////
  // Frame counters.
  localparam logic [2:0] BIT_FIRST      = 3'h0;
  localparam logic [2:0] BIT_LAST       = 3'h7;
  localparam logic [1:0] ADDR_BYTES_END = 2'h2;

  typedef enum logic [1:0] {
    PH_OPCODE = 2'b00,
    PH_ADDR   = 2'b01,
    PH_DATA   = 2'b10,
    PH_IDLE   = 2'b11
  } smwp_phase_e;

  typedef struct packed {
    logic       pge;
    logic [1:0] sel;
    logic       latch;
  } smwp_status_s;

  function automatic logic smwp_protected(input logic [17:0] a,
                                          input logic [1:0]  sel);
    case (sel)
      SEL_NONE:    smwp_protected = 1'b0;
      SEL_QUARTER: smwp_protected = (a >= BASE_QUARTER) && (a <= ADDR_LAST);
      SEL_HALF:    smwp_protected = (a >= BASE_HALF) && (a <= ADDR_LAST);
      SEL_ALL:     smwp_protected = (a >= BASE_ALL) && (a <= ADDR_LAST);
      default:     smwp_protected = 1'b1;
    endcase
  endfunction

  function automatic logic [7:0] smwp_status_byte(input smwp_status_s s);
    logic [7:0] b;
    b = 8'h00;
    b[BIT_PGE]    = s.pge;
    b[BIT_ONE]    = 1'b1;
    b[BIT_SEL_HI] = s.sel[1];
    b[BIT_SEL_LO] = s.sel[0];
    b[BIT_LATCH]  = s.latch;
    smwp_status_byte = b;
  endfunction

endpackage
`default_nettype wire

// ===== hw/smwp_sync.sv
`default_nettype none
module smwp_sync #(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  // The first stage is read only by the second stage.
  logic [W-1:0] meta = INIT;

  always_ff @(posedge clk) begin
    meta <= d;
    q    <= meta;
  end

endmodule
`default_nettype wire

// ===== hw/smwp_core.sv
`default_nettype none
// Operation
// [RULE1] Bits 0,4,5 read zero; bit 6 one.
// [RULE2] Bit 1 shows latch; reset clears it.
// [RULE3] Status write never touches the latch bit.
// [RULE4] Latch clear refuses all later writes.
// [RULE5] Protect select bits survive reset.
// [RULE6] Select pair chooses none, quarter, half, all.
// [RULE7] Memory byte needs latch and unprotected address.
// [RULE8] Guard enable zero ignores guard pin.
// [RULE9] Enabled guard low refuses status writes.
// [RULE10] Guard pin never blocks memory writes.
// [RULE11] Status read shifts out status byte.
// [RULE12] Status write loads bits 7, 3, 2.
// [RULE13] Master sets latch before each status write.
// [RULE14] Status write clears the latch.
// [RULE15] Master holds guard high before status write.
// [RULE16] Busy bit always reads zero.
// [RULE17] Factory state: no protection, guard ignored.
// [RULE18] Opcode 04h is the latch clear command.
// [RULE19] Chip select rise clears latch after writes.
// [RULE20] Only latch set command sets latch.
// [RULE21] Output stays off during status write.
module smwp_core (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        sck,
  input  wire logic        cs_n,
  input  wire logic        si,
  input  wire logic        guard_n,
  output var  logic        so,
  output var  logic        so_oe_n,
  output var  logic        mem_wr_en,
  output var  logic [17:0] mem_addr,
  output var  logic [7:0]  mem_data,
  output var  logic [7:0]  status
);

  ////////////////////////////////////////////////////////////////////////////
  // Link side, clocked by sck. A high chip select ends the frame at once,
  // since sck may stop right after the last bit.

  smwp_pkg::smwp_phase_e phase;
  logic [2:0]            bit_idx;
  logic [1:0]            addr_cnt;
  logic                  burst_stop;
  logic [7:0]            shift_in = 8'h00;
  logic [7:0]            opcode   = 8'h00;
  logic [7:0]            stat_data = 8'h00;
  logic                  op_tog   = 1'b0;
  logic                  stat_tog = 1'b0;
  logic [17:0]           wr_ptr   = 18'h00000;
  logic [7:0]            byte_in;
  logic                  byte_done;
  logic                  wr_allowed;
  smwp_pkg::smwp_status_s st_k;
  smwp_pkg::smwp_status_s st_clk;
  logic [7:0]            stat_byte_k;

  assign byte_in     = {shift_in[6:0], si};
  assign byte_done   = (bit_idx == smwp_pkg::BIT_LAST);
  assign stat_byte_k = smwp_pkg::smwp_status_byte(st_k);
  // The guard pin plays no part here: it only protects the status byte.
  assign wr_allowed  = st_k.latch &&
                       !smwp_pkg::smwp_protected(wr_ptr, st_k.sel); // [RULE7] [RULE10] [RULE6]

  // Protection settings reach the link through a two-stage synchroniser.
  // They only change between frames, and the first opcode byte gives eight
  // edges, more than the two needed to flush any stale value left from the last frame.
  smwp_sync #(
    .W    (4),
    .INIT (4'h0)
  ) u_sync_status (
    .clk (sck),
    .d   (st_clk),
    .q   (st_k)
  );

  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      bit_idx <= smwp_pkg::BIT_FIRST;
    end else begin
      bit_idx <= bit_idx + 3'h1;
    end
  end

  always_ff @(posedge sck) begin
    shift_in <= byte_in;
  end

  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      phase      <= smwp_pkg::PH_OPCODE;
      addr_cnt   <= 2'h0;
      burst_stop <= 1'b0;
    end else if (byte_done) begin
      case (phase)
        smwp_pkg::PH_OPCODE: begin
          if (byte_in == smwp_pkg::OP_STATUS_WRITE) begin
            phase <= smwp_pkg::PH_DATA;
          end else if (byte_in == smwp_pkg::OP_MEM_WRITE) begin
            phase <= smwp_pkg::PH_ADDR;
          end else begin
            phase <= smwp_pkg::PH_IDLE;
          end
        end
        smwp_pkg::PH_ADDR: begin
          addr_cnt <= addr_cnt + 2'h1;
          if (addr_cnt == smwp_pkg::ADDR_BYTES_END) begin
            phase <= smwp_pkg::PH_DATA;
          end
        end
        smwp_pkg::PH_DATA: begin
          if (opcode == smwp_pkg::OP_STATUS_WRITE) begin
            phase <= smwp_pkg::PH_IDLE;
          end else if (!wr_allowed) begin
            burst_stop <= 1'b1;
          end
        end
        default: begin
          phase <= smwp_pkg::PH_IDLE;
        end
      endcase
    end
  end

  // Opcode and data words are not cleared by chip select: the system side
  // reads them after the frame, qualified by the toggles.
  always_ff @(posedge sck) begin
    if (byte_done && phase == smwp_pkg::PH_OPCODE) begin
      opcode <= byte_in;
      op_tog <= ~op_tog;
    end
    if (byte_done && phase == smwp_pkg::PH_DATA &&
        opcode == smwp_pkg::OP_STATUS_WRITE) begin
      stat_data <= byte_in;
      stat_tog  <= ~stat_tog;
    end
  end

  always_ff @(posedge sck) begin
    if (byte_done && phase == smwp_pkg::PH_ADDR) begin
      wr_ptr <= {wr_ptr[9:0], byte_in};
    end else if (byte_done && phase == smwp_pkg::PH_DATA &&
                 opcode == smwp_pkg::OP_MEM_WRITE &&
                 !burst_stop && wr_allowed) begin
      wr_ptr <= wr_ptr + smwp_pkg::ADDR_STEP;
    end
  end

  // A stopped burst neither writes nor advances the address.
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      mem_wr_en <= 1'b0;
    end else begin
      mem_wr_en <= byte_done && phase == smwp_pkg::PH_DATA &&
                   opcode == smwp_pkg::OP_MEM_WRITE &&
                   !burst_stop && wr_allowed; // [RULE7]
    end
  end

  always_ff @(posedge sck) begin
    if (byte_done && phase == smwp_pkg::PH_DATA &&
        opcode == smwp_pkg::OP_MEM_WRITE) begin
      mem_addr <= wr_ptr;
      mem_data <= byte_in;
    end
  end

  // Output changes on the falling edge. Only a status read drives it;
  // every other command, the status write included, leaves it off.
  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      so      <= 1'b0;
      so_oe_n <= 1'b1;
    end else if (phase != smwp_pkg::PH_OPCODE &&
                 opcode == smwp_pkg::OP_STATUS_READ) begin
      so      <= stat_byte_k[smwp_pkg::BIT_LAST - bit_idx]; // [RULE11]
      so_oe_n <= 1'b0;
    end else begin
      so      <= 1'b0;
      so_oe_n <= 1'b1; // [RULE21]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // System side, clocked by clk.

  logic       cs_s;
  logic       cs_d;
  logic       guard_s;
  logic       op_tog_s;
  logic       stat_tog_s;
  logic       op_seen;
  logic       stat_seen;
  logic       frame_end;
  logic       op_new;
  logic       stat_new;
  logic       guard_block;
  logic       stat_ok;
  logic       latch;
  // Nonvolatile settings: the reset does not touch them, they start at the
  // factory values.
  logic       pge = smwp_pkg::FACTORY_PGE; // [RULE17]
  logic [1:0] sel = smwp_pkg::FACTORY_SEL; // [RULE17]

  smwp_sync #(
    .W    (4),
    .INIT (4'hc)
  ) u_sync_link (
    .clk (clk),
    .d   ({cs_n, guard_n, op_tog, stat_tog}),
    .q   ({cs_s, guard_s, op_tog_s, stat_tog_s})
  );

  assign frame_end   = cs_s && !cs_d;
  assign op_new      = frame_end && (op_tog_s != op_seen);
  assign stat_new    = frame_end && (stat_tog_s != stat_seen);
  assign guard_block = pge && !guard_s; // [RULE8] [RULE9]
  assign stat_ok     = stat_new && latch && !guard_block; // [RULE9] [RULE13]
  assign st_clk      = '{pge: pge, sel: sel, latch: latch};

  always_ff @(posedge clk) begin
    if (rst) begin
      cs_d      <= 1'b1;
      op_seen   <= op_tog_s;
      stat_seen <= stat_tog_s;
    end else begin
      cs_d <= cs_s;
      if (frame_end) begin
        op_seen   <= op_tog_s;
        stat_seen <= stat_tog_s;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      latch <= 1'b0; // [RULE2]
    end else if (op_new) begin
      case (opcode)
        smwp_pkg::OP_LATCH_SET:    latch <= 1'b1; // [RULE20]
        smwp_pkg::OP_LATCH_CLEAR:  latch <= 1'b0; // [RULE18] [RULE4] [RULE19]
        smwp_pkg::OP_STATUS_WRITE: latch <= 1'b0; // [RULE14] [RULE19]
        smwp_pkg::OP_MEM_WRITE:    latch <= 1'b0; // [RULE19]
        default:                   latch <= latch;
      endcase
    end
  end

  // The written latch position and the fixed bits are dropped.
  always_ff @(posedge clk) begin
    if (stat_ok) begin
      pge <= stat_data[smwp_pkg::BIT_PGE];    // [RULE12] [RULE3]
      sel <= {stat_data[smwp_pkg::BIT_SEL_HI],
              stat_data[smwp_pkg::BIT_SEL_LO]}; // [RULE5] [RULE12]
    end
  end

  always_ff @(posedge clk) begin
    status <= smwp_pkg::smwp_status_byte(st_clk); // [RULE1] [RULE16]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence s_cmd_end(logic [7:0] op);
    op_new && opcode == op;
  endsequence

  sequence s_stat_refused;
    stat_new && (!latch || guard_block);
  endsequence

  a_latch_set: assert property ( // [RULE20]
    @(posedge clk) disable iff (rst)
    s_cmd_end(smwp_pkg::OP_LATCH_SET) |=> latch ##1 status[1])
    else $error("latch not set after set command");

  a_latch_clear: assert property ( // [RULE4]
    @(posedge clk) disable iff (rst)
    s_cmd_end(smwp_pkg::OP_LATCH_CLEAR) |=> !latch ##1 !status[1])
    else $error("latch not cleared after clear command");

  a_status_wr_clears: assert property ( // [RULE14]
    @(posedge clk) disable iff (rst)
    s_cmd_end(smwp_pkg::OP_STATUS_WRITE) |=> !latch)
    else $error("latch not cleared after status write");

  a_memwr_clears: assert property ( // [RULE19]
    @(posedge clk) disable iff (rst)
    s_cmd_end(smwp_pkg::OP_MEM_WRITE) |=> !latch)
    else $error("latch not cleared after memory write");

  a_latch_origin: assert property ( // [RULE20]
    @(posedge clk) disable iff (rst)
    $rose(latch) |-> $past(op_new && opcode == smwp_pkg::OP_LATCH_SET))
    else $error("latch rose without set command");

  a_reset_latch: assert property ( // [RULE2]
    @(posedge clk) disable iff (1'b0)
    rst |=> !latch)
    else $error("latch not cleared by reset");

  a_fixed_bits: assert property ( // [RULE1]
    @(posedge clk) disable iff (rst)
    !status[0] && !status[5] && !status[4] && status[6])
    else $error("fixed status bits wrong");

  a_stat_refused: assert property ( // [RULE9]
    @(posedge clk) disable iff (rst)
    s_stat_refused |=> $stable(pge) && $stable(sel) ##1 $stable(status[7]))
    else $error("refused status write changed settings");

  a_stat_update: assert property ( // [RULE12]
    @(posedge clk) disable iff (rst)
    stat_ok |=> pge == $past(stat_data[7]) && sel == $past(stat_data[3:2])
             ##1 status[7] == pge && status[3:2] == sel)
    else $error("status write did not load settings");

  a_guard_ignored: assert property ( // [RULE8]
    @(posedge clk) disable iff (rst)
    stat_new && latch && !pge |=> sel == $past(stat_data[3:2]))
    else $error("guard pin blocked write while disabled");

  a_mem_guard: assert property ( // [RULE7]
    @(posedge sck) disable iff (cs_n)
    mem_wr_en |-> $past(st_k.latch) &&
                  !smwp_pkg::smwp_protected(mem_addr, $past(st_k.sel)))
    else $error("memory write into protected or disabled state");

  a_so_quiet: assert property ( // [RULE21]
    @(posedge sck) disable iff (cs_n)
    (phase == smwp_pkg::PH_OPCODE ||
     opcode == smwp_pkg::OP_STATUS_WRITE) |-> so_oe_n)
    else $error("output driven outside status read");

  a_read_bits: assert property ( // [RULE11]
    @(posedge sck) disable iff (cs_n)
    phase == smwp_pkg::PH_IDLE && opcode == smwp_pkg::OP_STATUS_READ
    |-> !so_oe_n && so == stat_byte_k[smwp_pkg::BIT_LAST - bit_idx])
    else $error("status read bit wrong");

  a_burst_halt: assert property ( // [RULE7]
    @(posedge sck) disable iff (cs_n)
    burst_stop |-> !mem_wr_en)
    else $error("memory write after burst stop");

endmodule
`default_nettype wire

// ===== verif/smwp_spi_master.sv
`default_nettype none
module smwp_spi_master (
  input  wire logic        clk,
  input  wire logic        so,
  input  wire logic        so_oe_n,
  input  wire logic        mem_wr_en,
  input  wire logic [17:0] mem_addr,
  input  wire logic [7:0]  mem_data,
  output var  logic        sck,
  output var  logic        cs_n,
  output var  logic        si
);
  timeunit 1ns;
  timeprecision 100ps;

  logic        drove;
  logic        wr_seen;
  logic [17:0] wr_addr;
  logic [7:0]  wr_data;
  int          n_wr;
  logic [17:0] last_addr;
  logic [7:0]  last_data;

  // A chip select rise at 5 ns, held until the first frame, puts the link logic into its opcode
  // state, as the power-up of a real bus would.
  initial begin
    sck       = 1'b0;
    cs_n      = 1'b0;
    si        = 1'b0;
    drove     = 1'b0;
    wr_seen   = 1'b0;
    wr_addr   = 18'h00000;
    wr_data   = 8'h00;
    n_wr      = 0;
    last_addr = 18'h00000;
    last_data = 8'h00;
    #5;
    cs_n = 1'b1;
  end

  // The array takes each strobe on the falling edge of the link clock.
  always @(negedge sck) begin
    if (mem_wr_en) begin
      n_wr++;
      last_addr = mem_addr;
      last_data = mem_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode 0: the link clock stands low between frames and runs only inside.
  task automatic begin_frame;
    @(posedge clk);
    cs_n <= 1'b0;
    drove = 1'b0;
    n_wr = 0;
    #31;
  endtask

  task automatic xfer(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      si <= d[i];
      #24;
      // A released line shows the inverse here, so it cannot pass a read.
      q[i] = so_oe_n ? ~so : so;
      drove = drove | ~so_oe_n;
      sck <= 1'b1;
      #24;
      sck <= 1'b0;
    end
  endtask

  // The strobe stands until the next rise, so it is caught before release.
  task automatic end_frame;
    #12;
    wr_seen = mem_wr_en;
    wr_addr = mem_addr;
    wr_data = mem_data;
    cs_n <= 1'b1;
    si   <= ~si;
    repeat (8) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ===== verif/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk;
  logic        rst;
  logic        guard_n;
  logic        sck;
  logic        cs_n;
  logic        si;
  logic        so;
  logic        so_oe_n;
  logic        mem_wr_en;
  logic [17:0] mem_addr;
  logic [7:0]  mem_data;
  logic [7:0]  status;
  int          n_mismatch;
  int          compares;

  smwp_core dut (
    .clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si),
    .guard_n(guard_n), .so(so), .so_oe_n(so_oe_n), .mem_wr_en(mem_wr_en),
    .mem_addr(mem_addr), .mem_data(mem_data), .status(status)
  );

  smwp_spi_master master (
    .clk(clk), .so(so), .so_oe_n(so_oe_n), .mem_wr_en(mem_wr_en),
    .mem_addr(mem_addr), .mem_data(mem_data), .sck(sck), .cs_n(cs_n),
    .si(si)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cmd(input logic [7:0] op);
    logic [7:0] q;
    master.begin_frame();
    master.xfer(op, q);
    master.end_frame();
  endtask

  task automatic write_status(input logic [7:0] d, input logic set);
    logic [7:0] q;
    if (set) cmd(smwp_pkg::OP_LATCH_SET);
    master.begin_frame();
    master.xfer(smwp_pkg::OP_STATUS_WRITE, q);
    master.xfer(d, q);
    master.end_frame();
  endtask

  task automatic read_status(output logic [7:0] q);
    master.begin_frame();
    master.xfer(smwp_pkg::OP_STATUS_READ, q);
    master.xfer(8'h00, q);
    master.end_frame();
  endtask

  task automatic mem_write(input logic [17:0] a, input logic [7:0] d);
    logic [7:0] q;
    master.begin_frame();
    master.xfer(smwp_pkg::OP_MEM_WRITE, q);
    master.xfer({6'h00, a[17:16]}, q);
    master.xfer(a[15:8], q);
    master.xfer(a[7:0], q);
    master.xfer(d, q);
    master.end_frame();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_state;
    logic [7:0] q;
    check(18'(status), 18'h40);
    read_status(q);
    check(18'(q), 18'h40);
    check(18'(master.drove), 18'h1);
    $display("test reset_state done");
  endtask

  task automatic t_latch;
    logic [7:0] q;
    cmd(smwp_pkg::OP_LATCH_SET);
    check(18'(status), 18'h42);
    read_status(q);
    check(18'(q), 18'h42);
    cmd(smwp_pkg::OP_LATCH_CLEAR);
    check(18'(status), 18'h40);
    mem_write(18'h00010, 8'h5a);
    check(18'(master.wr_seen), 18'h0);
    $display("test latch done");
  endtask

  task automatic t_status_write;
    write_status(8'hff, 1'b0);
    check(18'(status), 18'h40);
    write_status(8'h02, 1'b1);
    check(18'(status), 18'h40);
    write_status(8'hff, 1'b1);
    check(18'(status), 18'hcc);
    check(18'(status[1]), 18'h0);
    check(18'(master.drove), 18'h0);
    write_status(8'h37, 1'b1);
    check(18'(status), 18'h44);
    $display("test status_write done");
  endtask

  task automatic t_guard;
    write_status(8'h80, 1'b1);
    @(posedge clk) guard_n <= 1'b0;
    write_status(8'h8c, 1'b1);
    check(18'(status), 18'hc0);
    cmd(smwp_pkg::OP_LATCH_SET);
    mem_write(18'h3ffff, 8'ha5);
    check(18'(master.wr_seen), 18'h1);
    check(18'(master.wr_data), 18'ha5);
    @(posedge clk) guard_n <= 1'b1;
    write_status(8'h04, 1'b1);
    check(18'(status), 18'h44);
    @(posedge clk) guard_n <= 1'b0;
    write_status(8'h08, 1'b1);
    check(18'(status), 18'h48);
    @(posedge clk) guard_n <= 1'b1;
    $display("test guard done");
  endtask

  // Each select code against the edges of every protected range.
  task automatic t_blocks;
    logic [17:0] addrs [6] = '{18'h00000, 18'h1ffff, 18'h20000,
                               18'h2ffff, 18'h30000, 18'h3ffff};
    logic        hit;
    for (int s = 0; s < 4; s++) begin
      write_status({4'h0, s[1:0], 2'h0}, 1'b1);
      for (int i = 0; i < 6; i++) begin
        hit = (s == 1 && addrs[i] >= 18'h30000) ||
              (s == 2 && addrs[i] >= 18'h20000) || s == 3;
        cmd(smwp_pkg::OP_LATCH_SET);
        mem_write(addrs[i], 8'h11 + 8'(i));
        check(18'(master.wr_seen), 18'(!hit));
        if (!hit) check(master.wr_addr, addrs[i]);
        if (!hit) check(18'(master.wr_data), 18'h11 + 18'(i));
        check(18'(status[1]), 18'h0);
      end
    end
    $display("test blocks done");
  endtask

  // Settings outlive a reset while the latch does not.
  task automatic t_reset_keeps;
    cmd(smwp_pkg::OP_LATCH_SET);
    check(18'(status), 18'h4e);
    @(posedge clk) rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    check(18'(status), 18'h4c);
    $display("test reset_keeps done");
  endtask

  // A burst runs into the protected quarter: two bytes land, the rest not.
  task automatic t_burst;
    logic [7:0] q;
    write_status(8'h04, 1'b1);
    cmd(smwp_pkg::OP_LATCH_SET);
    master.begin_frame();
    master.xfer(smwp_pkg::OP_MEM_WRITE, q);
    master.xfer(8'h02, q);
    master.xfer(8'hff, q);
    master.xfer(8'hfe, q);
    master.xfer(8'ha1, q);
    master.xfer(8'ha2, q);
    master.xfer(8'ha3, q);
    master.xfer(8'ha4, q);
    master.end_frame();
    check(18'(master.n_wr), 18'h2);
    check(master.last_addr, 18'h2ffff);
    check(18'(master.last_data), 18'ha2);
    check(18'(master.wr_seen), 18'h0);
    check(18'(status), 18'h44);
    $display("test burst done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #1000000;
    n_mismatch++;
    complete_run();
  end

  initial begin
    rst        = 1'b1;
    guard_n    = 1'b1;
    n_mismatch = 0;
    compares   = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_reset_state();
    t_latch();
    t_status_write();
    t_guard();
    t_blocks();
    t_reset_keeps();
    t_burst();
    complete_run();
  end
endmodule
`default_nettype wire
